// *** hdl/ues_core.sv ***
// Transfer status FIFO, endpoint control, address, frame and USB RAM
//
// Behaviour
// - Four-deep status FIFO, head shown in window
// - Completed transfers push entries in arrival order
// - Flag clear pops; refilled flag within 6 Tcy
// - Empty after pop keeps flag clear
// - Token with full FIFO answered by NAK
// - Entry bits 6..3 hold endpoint number
// - Entry bit 2 set for IN token
// - Entry bit 1 odd bank; bits 7,0 zero
// - Sixteen endpoint control registers, bits 7..5 zero
// - Bit 4 enables handshakes for accepted tokens; NAK always sends one
// - Bit 3 rejects SETUP when both directions on
// - Bit 2 enables OUT, bit 1 enables IN
// - Halt bit set on STALL, firmware clears
// - Address cleared on bus reset and reset
// - Respond only to tokens matching device address
// - Eleven-bit frame number split low/high
// - Frame loaded on SOF, read-only
// - Dual-access RAM from 60h to F3Fh
// - Bank 400h..4FFh reserved for descriptors
// - Descriptor bit 7 ownership, engine clears on done
// - Descriptor stall sets halt, raises stall event
`timescale 1ns/1ps
module ues_core
  import ues_pkg::*;
#(
  parameter int FIFO_DEPTH = 4,
  parameter int NUM_EP     = 16
) (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // Processor data-memory port
  input  wire logic [11:0]         cpu_addr,
  input  wire logic                cpu_wr,
  input  wire logic [7:0]          cpu_wdata,
  output logic      [7:0]          cpu_rdata,
  // Token decode from the serial engine
  input  wire logic                tok_valid,
  input  wire ues_pkg::ues_pid_t   tok_pid,
  input  wire logic [6:0]          tok_addr,
  input  wire logic [3:0]          tok_ep,
  input  wire logic [10:0]         tok_frame,
  output logic                     tok_accept,
  output logic                     tok_nak,
  output logic                     tok_ignore,
  output logic                     tok_hshk,
  // Transfer completion and stall events from the engine
  input  wire logic                xfer_done,
  input  wire logic [3:0]          xfer_ep,
  input  wire logic                xfer_dir,
  input  wire logic                xfer_odd,
  input  wire logic                stall_sent,
  input  wire logic [3:0]          stall_ep,
  input  wire logic                bus_reset,
  output logic                     stall_event,
  output logic                     transfer_done_flag,
  // Engine side of the USB RAM
  input  wire logic [11:0]         eng_addr,
  input  wire logic                eng_wr,
  input  wire logic [7:0]          eng_wdata,
  output logic      [7:0]          eng_rdata
);
  import ues_pkg::*;

  localparam int PW = $clog2(FIFO_DEPTH);

  logic [6:0]    fifo_q [FIFO_DEPTH];
  logic [PW-1:0] rd_ptr_q;
  logic [PW-1:0] wr_ptr_q;
  logic [PW:0]   count_q;
  logic [4:0]    ep_ctl_q [NUM_EP];
  logic [7:0]    dev_addr_q;
  logic [10:0]   frame_q;
  logic [7:0]    ram_q [RAM_WORDS];
  ues_flag_t     flag_q;
  logic [4:0]    wait_q;
  logic          fifo_full;
  logic          fifo_empty;
  logic          push;
  logic          pop;
  logic          cpu_ram_hit;
  logic          eng_ram_hit;
  logic [11:0]   cpu_idx;
  logic [11:0]   eng_idx;
  logic [11:0]   own_idx;
  logic [4:0]    tok_ctl;
  logic          tok_ok;
  logic [7:0]    head;

  // FIFO bookkeeping; a full FIFO drops the push, host was NAKed
  assign fifo_full  = (count_q == (PW+1)'(FIFO_DEPTH));
  assign fifo_empty = (count_q == '0);
  assign push       = xfer_done && !fifo_full;
  // Only a write of zero to the flag bit while set advances
  assign pop = cpu_wr && cpu_addr == DONE_FLAG_ADDR && !cpu_wdata[0] &&
               flag_q == FL_SET && !fifo_empty;
  // Head entry layout: 0, endpoint, direction, bank, 0
  assign head = {1'b0, fifo_q[rd_ptr_q][6:3], fifo_q[rd_ptr_q][2],
                 fifo_q[rd_ptr_q][1], 1'b0};

  // Status entry storage
  always_ff @(posedge sys_clk) begin
    if (push) begin
      fifo_q[wr_ptr_q] <= {xfer_ep, xfer_dir, xfer_odd, 1'b0};
    end
  end

  // Pointers and occupancy, first in first out
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_ptr_q <= '0;
      wr_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Done flag: set by a waiting entry, re-raised after a short gap
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag_q <= FL_IDLE;
      wait_q <= '0;
    end else begin
      case (flag_q)
        FL_IDLE: begin
          if (!fifo_empty || push) begin
            flag_q <= FL_SET;
          end
        end
        FL_SET: begin
          if (pop) begin
            flag_q <= FL_WAIT;
            wait_q <= REASSERT_CYC;
          end
        end
        FL_WAIT: begin
          // Gap lets firmware see the clear; well under the 6 Tcy limit
          if (wait_q > 5'h01) begin
            wait_q <= wait_q - 5'h01;
          end else if (!fifo_empty || push) begin
            flag_q <= FL_SET;
          end else begin
            flag_q <= FL_IDLE;
          end
        end
        default: flag_q <= FL_IDLE;
      endcase
    end
  end

  // One-hot state, so the FL_SET bit is itself the flag flip-flop
  assign transfer_done_flag = flag_q[1];

  // Endpoint control; engine stall set wins over a firmware clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_EP; i++) begin
        ep_ctl_q[i] <= EP_CTL_RST;
      end
    end else begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (cpu_wr && cpu_addr == EP_CTL_BASE + 12'(i)) begin
          ep_ctl_q[i] <= cpu_wdata[4:0];
        end
        if (stall_sent && stall_ep == 4'(i)) begin
          ep_ctl_q[i][EP_HALT_BIT] <= 1'b1;
        end
      end
    end
  end

  // Stall event pulse toward the interrupt logic
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stall_event <= 1'b0;
    end else begin
      stall_event <= stall_sent;
    end
  end

  // Device address; bus reset clears it like a device reset
  always_ff @(posedge sys_clk) begin
    if (reset || bus_reset) begin
      dev_addr_q <= DEV_ADDR_RST;
    end else if (cpu_wr && cpu_addr == DEV_ADDR_ADDR) begin
      dev_addr_q <= {1'b0, cpu_wdata[6:0]};
    end
  end

  // Frame number loaded from each SOF, no processor write path
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      frame_q <= '0;
    end else if (tok_valid && tok_pid == PID_SOF) begin
      frame_q <= tok_frame;
    end
  end

  // Token qualification for the addressed endpoint
  assign tok_ctl = ep_ctl_q[tok_ep];
  always_comb begin
    case (tok_pid)
      PID_OUT:   tok_ok = tok_ctl[EP_OUT_BIT];
      PID_IN:    tok_ok = tok_ctl[EP_IN_BIT];
      PID_SETUP: tok_ok = tok_ctl[EP_OUT_BIT] && tok_ctl[EP_IN_BIT] &&
                          !tok_ctl[EP_SETUP_BIT];
      default:   tok_ok = 1'b0;
    endcase
  end

  // Token answer, registered; other addresses get no reply at all
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tok_accept <= 1'b0;
      tok_nak    <= 1'b0;
      tok_ignore <= 1'b0;
      tok_hshk   <= 1'b0;
    end else begin
      tok_accept <= 1'b0;
      tok_nak    <= 1'b0;
      tok_ignore <= 1'b0;
      tok_hshk   <= 1'b0;
      if (tok_valid && tok_pid != PID_SOF) begin
        if ({1'b0, tok_addr} != dev_addr_q) begin
          tok_ignore <= 1'b1;
        end else if (!tok_ok) begin
          tok_ignore <= 1'b1;
        end else if (fifo_full) begin
          tok_nak  <= 1'b1;
          tok_hshk <= 1'b1;
        end else begin
          tok_accept <= 1'b1;
          tok_hshk   <= tok_ctl[EP_HSHK_BIT];
        end
      end
    end
  end

  // RAM decode; descriptor status byte for the finished transfer
  assign cpu_ram_hit = cpu_addr >= RAM_LO && cpu_addr <= RAM_HI;
  assign eng_ram_hit = eng_addr >= RAM_LO && eng_addr <= RAM_HI;
  assign cpu_idx     = cpu_addr - RAM_LO;
  assign eng_idx     = eng_addr - RAM_LO;
  assign own_idx     = BD_LO + {4'h0, xfer_ep, xfer_dir, xfer_odd, 2'b00}
                       - RAM_LO;

  // Dual-access RAM; no hardware lockout, ownership is by convention
  always_ff @(posedge sys_clk) begin
    if (cpu_wr && cpu_ram_hit) begin
      ram_q[cpu_idx] <= cpu_wdata;
    end
    if (eng_wr && eng_ram_hit) begin
      ram_q[eng_idx] <= eng_wdata;
    end
    if (xfer_done) begin
      ram_q[own_idx][OWN_BIT] <= 1'b0;
    end
  end

  // Engine read port, one cycle latency
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      eng_rdata <= 8'h00;
    end else begin
      eng_rdata <= eng_ram_hit ? ram_q[eng_idx] : 8'h00;
    end
  end

  // Processor read mux, one cycle latency, reads have no side effect
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_ram_hit) begin
      cpu_rdata <= ram_q[cpu_idx];
    end else if (cpu_addr >= EP_CTL_BASE &&
                 cpu_addr < EP_CTL_BASE + 12'(NUM_EP)) begin
      cpu_rdata <= {3'b000, ep_ctl_q[4'(cpu_addr - EP_CTL_BASE)]};
    end else begin
      case (cpu_addr)
        STAT_WIN_ADDR:  cpu_rdata <= head;
        DONE_FLAG_ADDR: cpu_rdata <= {7'h00, transfer_done_flag};
        DEV_ADDR_ADDR:  cpu_rdata <= dev_addr_q;
        FRM_LO_ADDR:    cpu_rdata <= frame_q[7:0];
        FRM_HI_ADDR:    cpu_rdata <= {5'h00, frame_q[10:8]};
        default:        cpu_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// *** hdl/ues_pkg.sv ***
// Constants shared by the endpoint status and control block
package ues_pkg;
  // Processor data-memory map of the control registers
  localparam logic [11:0] STAT_WIN_ADDR  = 12'hF60;
  localparam logic [11:0] DONE_FLAG_ADDR = 12'hF61;
  localparam logic [11:0] DEV_ADDR_ADDR  = 12'hF62;
  localparam logic [11:0] FRM_LO_ADDR    = 12'hF63;
  localparam logic [11:0] FRM_HI_ADDR    = 12'hF64;
  localparam logic [11:0] EP_CTL_BASE    = 12'hF70;
  // Dual-access RAM window and descriptor bank
  localparam logic [11:0] RAM_LO         = 12'h060;
  localparam logic [11:0] RAM_HI         = 12'hF3F;
  localparam logic [11:0] BD_LO          = 12'h400;
  localparam logic [11:0] BD_HI          = 12'h4FF;
  localparam int          RAM_WORDS      = 3808;
  // Endpoint control field positions
  localparam int          EP_HSHK_BIT    = 4;
  localparam int          EP_SETUP_BIT   = 3;
  localparam int          EP_OUT_BIT     = 2;
  localparam int          EP_IN_BIT      = 1;
  localparam int          EP_HALT_BIT    = 0;
  localparam logic [4:0]  EP_CTL_RST     = 5'h00;
  localparam logic [7:0]  DEV_ADDR_RST   = 8'h00;
  localparam int          OWN_BIT        = 7;
  // Flag re-raise: limit is 6 instruction cycles of 4 clocks each
  localparam int          TCY_NS         = 160;
  localparam int          REASSERT_TCY   = 6;
  localparam int          CLK_NS         = 40;
  localparam int          REASSERT_MAX   = REASSERT_TCY * TCY_NS / CLK_NS;
  localparam logic [4:0]  REASSERT_CYC   = 5'h02;
  // Token identifiers from the serial engine
  typedef enum logic [1:0] {
    PID_OUT   = 2'h0,
    PID_IN    = 2'h1,
    PID_SETUP = 2'h2,
    PID_SOF   = 2'h3
  } ues_pid_t;
  // Flag sequencing states
  typedef enum logic [2:0] {
    FL_IDLE = 3'b001,
    FL_SET  = 3'b010,
    FL_WAIT = 3'b100
  } ues_flag_t;
endpackage

// *** verification/tb_top.sv ***
// Self-checking bench for the endpoint status block
`timescale 1ns/1ps
module tb_top;
  import ues_pkg::*;
  logic        sys_clk, reset, cpu_wr, xfer_done, xfer_dir, xfer_odd;
  logic        stall_sent, bus_reset, rd_req, rd_d, tok_valid;
  logic        tok_accept, tok_nak, tok_ignore, tok_hshk;
  logic        stall_event, transfer_done_flag, eng_wr;
  logic [11:0] cpu_addr, eng_addr;
  logic [7:0]  cpu_wdata, cpu_rdata, eng_wdata, eng_rdata;
  logic [3:0]  xfer_ep, stall_ep, tok_ep;
  logic [6:0]  tok_addr, da;
  logic [10:0] tok_frame, fr;
  ues_pid_t    tok_pid;
  logic [7:0]  rdq[$], tkq[$], ep_v[16];
  logic [5:0]  ent[5];
  int          failures, checks, cyc, stall_seen;
  ues_host host_u (.sys_clk(sys_clk), .tok_valid(tok_valid),
    .tok_pid(tok_pid), .tok_addr(tok_addr), .tok_ep(tok_ep),
    .tok_frame(tok_frame));
  // Engine RAM port driven by the bench to reach the shared RAM
  ues_core dut_u (.sys_clk(sys_clk), .reset(reset), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_addr(tok_addr),
    .tok_ep(tok_ep), .tok_frame(tok_frame), .tok_accept(tok_accept),
    .tok_nak(tok_nak), .tok_ignore(tok_ignore), .tok_hshk(tok_hshk),
    .xfer_done(xfer_done), .xfer_ep(xfer_ep), .xfer_dir(xfer_dir),
    .xfer_odd(xfer_odd), .stall_sent(stall_sent), .stall_ep(stall_ep),
    .bus_reset(bus_reset), .stall_event(stall_event),
    .transfer_done_flag(transfer_done_flag), .eng_addr(eng_addr),
    .eng_wr(eng_wr), .eng_wdata(eng_wdata), .eng_rdata(eng_rdata));
  always #20 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [7:0] s, e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge sys_clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    rdq.push_back(e);
    @(posedge sys_clk);
    cpu_addr <= a;
    rd_req <= 1'b1;
    @(posedge sys_clk);
    rd_req <= 1'b0;
  endtask
  // Expected answer packs accept, refuse, ignore, handshake
  task automatic tk(input ues_pid_t p, input logic [6:0] a,
                    input logic [3:0] e, input logic [3:0] x);
    if (p != PID_SOF) tkq.push_back({4'h0, x});
    host_u.send(p, a, e, fr);
  endtask
  task automatic xf(input logic [5:0] x);
    @(posedge sys_clk);
    {xfer_ep, xfer_dir, xfer_odd} <= x;
    xfer_done <= 1'b1;
    @(posedge sys_clk);
    xfer_done <= 1'b0;
  endtask
  // Results are matched against the oldest note as they appear
  always @(posedge sys_clk) begin
    rd_d <= rd_req;
    if (stall_event) stall_seen++;
    if (rd_d) chk("cpu_rdata", cpu_rdata, rdq.pop_front());
    if (tok_accept | tok_nak | tok_ignore)
      chk("token answer", {4'h0, tok_accept, tok_nak, tok_ignore,
          tok_hshk & ~tok_ignore}, tkq.pop_front());
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    {sys_clk, cpu_wr, xfer_done, xfer_dir, xfer_odd} = 5'h00;
    {stall_sent, bus_reset, rd_req, rd_d, reset} = 5'h01;
    {cpu_addr, cpu_wdata, xfer_ep, stall_ep, fr} = 39'h0;
    {eng_addr, eng_wdata, eng_wr} = 21'h0;
    void'($urandom(32'h8B1F));
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    rd(DONE_FLAG_ADDR, 8'h00);
    rd(DEV_ADDR_ADDR, 8'h00);
    rd(FRM_HI_ADDR, 8'h00);
    rd(12'h05F, 8'h00);
    for (int n = 0; n < 16; n++) begin
      ep_v[n] = 8'($urandom);
      rd(EP_CTL_BASE + 12'(n), 8'h00);
      wr(EP_CTL_BASE + 12'(n), ep_v[n]);
      rd(EP_CTL_BASE + 12'(n), ep_v[n] & 8'h1F);
    end
    da = 7'($urandom);
    wr(DEV_ADDR_ADDR, {1'b1, da});
    rd(DEV_ADDR_ADDR, {1'b0, da});
    wr(EP_CTL_BASE + 12'h001, 8'h16);
    wr(EP_CTL_BASE + 12'h002, 8'h04);
    wr(EP_CTL_BASE + 12'h003, 8'h1E);
    tk(PID_IN, da, 4'h1, 4'h9);
    tk(PID_IN, da ^ 7'h01, 4'h1, 4'h2);
    tk(PID_SETUP, da, 4'h1, 4'h9);
    tk(PID_IN, da, 4'h2, 4'h2);
    tk(PID_OUT, da, 4'h2, 4'h8);
    tk(PID_SETUP, da, 4'h3, 4'h2);
    tk(PID_OUT, da, 4'h3, 4'h9);
    fr = 11'($urandom);
    tk(PID_SOF, da, 4'h0, 4'h0);
    wr(FRM_LO_ADDR, ~fr[7:0]);
    rd(FRM_LO_ADDR, fr[7:0]);
    rd(FRM_HI_ADDR, {5'h00, fr[10:8]});
    wr(RAM_LO, 8'hA5);
    wr(RAM_HI, 8'h5A);
    rd(RAM_LO, 8'hA5);
    rd(RAM_HI, 8'h5A);
    // Engine side of the shared RAM: write one byte, read back one the processor wrote
    @(posedge sys_clk);
    eng_addr <= BD_HI;
    eng_wdata <= 8'h3C;
    eng_wr <= 1'b1;
    @(posedge sys_clk);
    eng_wr <= 1'b0;
    eng_addr <= RAM_LO;
    rd(BD_HI, 8'h3C);
    chk("eng_rdata", eng_rdata, 8'hA5);
    // Fill the status queue, refuse while full, then drop one more
    for (int i = 0; i < 5; i++) ent[i] = 6'($urandom);
    wr(BD_LO + {4'h0, ent[0], 2'h0}, 8'hFF);
    for (int i = 0; i < 4; i++) xf(ent[i]);
    rd(BD_LO + {4'h0, ent[0], 2'h0}, 8'h7F);
    tk(PID_IN, da, 4'h1, 4'h5);
    xf(ent[4]);
    for (int i = 0; i < 4; i++) begin
      rd(DONE_FLAG_ADDR, 8'h01);
      chk("transfer_done_flag", 8'(transfer_done_flag), 8'h01);
      rd(STAT_WIN_ADDR, {1'b0, ent[i], 1'b0});
      rd(STAT_WIN_ADDR, {1'b0, ent[i], 1'b0});
      wr(DONE_FLAG_ADDR, 8'h00);
      @(posedge sys_clk);
      chk("transfer_done_flag", 8'(transfer_done_flag), 8'h00);
      // Next flag read is sampled within the re-raise limit of the pop
      repeat (REASSERT_MAX - 3) @(posedge sys_clk);
    end
    rd(DONE_FLAG_ADDR, 8'h00);
    @(posedge sys_clk);
    stall_ep <= 4'h5;
    stall_sent <= 1'b1;
    @(posedge sys_clk);
    stall_sent <= 1'b0;
    rd(EP_CTL_BASE + 12'h005, (ep_v[5] & 8'h1F) | 8'h01);
    wr(EP_CTL_BASE + 12'h005, 8'h00);
    rd(EP_CTL_BASE + 12'h005, 8'h00);
    // Halt set and firmware clear in one cycle: the set must win
    @(posedge sys_clk);
    cpu_addr <= EP_CTL_BASE + 12'h005;
    cpu_wdata <= 8'h00;
    cpu_wr <= 1'b1;
    stall_sent <= 1'b1;
    @(posedge sys_clk);
    cpu_wr <= 1'b0;
    stall_sent <= 1'b0;
    rd(EP_CTL_BASE + 12'h005, 8'h01);
    @(posedge sys_clk);
    bus_reset <= 1'b1;
    @(posedge sys_clk);
    bus_reset <= 1'b0;
    rd(DEV_ADDR_ADDR, 8'h00);
    tk(PID_OUT, 7'h00, 4'h2, 4'h8);
    // Mid-run reset must clear endpoint control, halt bit included
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    rd(EP_CTL_BASE + 12'h001, 8'h00);
    rd(EP_CTL_BASE + 12'h005, 8'h00);
    repeat (4) @(posedge sys_clk);
    chk("notes left", 8'(rdq.size() + tkq.size()), 8'h00);
    chk("stall_event", 8'(stall_seen), 8'h02);
    tally_and_finish();
  end
endmodule

// *** verification/ues_chk_checker.sv ***
// Port assertions for the endpoint status block
`timescale 1ns/1ps
module ues_chk
  import ues_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              reset,
  input wire logic [11:0]       cpu_addr,
  input wire logic              cpu_wr,
  input wire logic [7:0]        cpu_wdata,
  input wire logic              tok_valid,
  input wire ues_pkg::ues_pid_t tok_pid,
  input wire logic              tok_accept,
  input wire logic              tok_nak,
  input wire logic              tok_ignore,
  input wire logic              tok_hshk,
  input wire logic              xfer_done,
  input wire logic              stall_sent,
  input wire logic              stall_event,
  input wire logic              transfer_done_flag
);
  logic [2:0] cnt_q;
  logic       pop;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // Clear write landing while the flag is up
  assign pop = cpu_wr && cpu_addr == DONE_FLAG_ADDR && !cpu_wdata[0]
               && transfer_done_flag;
  // Shadow entry count; a push onto a full queue is lost
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'(xfer_done && cnt_q < 3'h4) - 3'(pop);
    end
  end
  stall_evt_a: assert property (stall_sent |=> stall_event)
    else $error("stall event missing after stall");
  tok_answer_a: assert property ((tok_valid && tok_pid != PID_SOF)
    |=> $onehot({tok_accept, tok_nak, tok_ignore}))
    else $error("token not answered exactly once");
  tok_quiet_a: assert property (!(tok_valid && tok_pid != PID_SOF)
    |=> !(tok_accept || tok_nak || tok_ignore))
    else $error("answer without a token");
  nak_hshk_a: assert property (tok_nak |-> tok_hshk)
    else $error("refusal sent without handshake");
  flag_pop_a: assert property (pop |=> !transfer_done_flag)
    else $error("flag stayed up after clear");
  flag_push_a: assert property ((xfer_done && cnt_q == 3'h0)
    |-> ##2 transfer_done_flag)
    else $error("flag not raised by first entry");
  flag_again_a: assert property ((pop && cnt_q > 3'h1)
    |-> ##[2:24] transfer_done_flag)
    else $error("flag not raised again for queued entry");
  flag_empty_a: assert property (cnt_q == 3'h0 |-> !transfer_done_flag)
    else $error("flag up with empty queue");
endmodule
bind ues_core ues_chk chk_u (
  .sys_clk(sys_clk), .reset(reset), .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .tok_valid(tok_valid),
  .tok_pid(tok_pid), .tok_accept(tok_accept), .tok_nak(tok_nak),
  .tok_ignore(tok_ignore), .tok_hshk(tok_hshk), .xfer_done(xfer_done),
  .stall_sent(stall_sent), .stall_event(stall_event),
  .transfer_done_flag(transfer_done_flag)
);

// *** verification/ues_host.sv ***
// Behavioural USB host issuing decoded tokens
`timescale 1ns/1ps
module ues_host
  import ues_pkg::*;
(
  input  wire logic              sys_clk,
  output logic                   tok_valid,
  output ues_pkg::ues_pid_t      tok_pid,
  output logic [6:0]             tok_addr,
  output logic [3:0]             tok_ep,
  output logic [10:0]            tok_frame
);
  initial begin
    tok_valid = 1'b0;
    tok_pid = PID_OUT;
    tok_addr = 7'h00;
    tok_ep = 4'h0;
    tok_frame = 11'h000;
  end
  // One-cycle token; address, endpoint and frame inverted after so stale values never match
  task automatic send(input ues_pid_t p, input logic [6:0] a,
                      input logic [3:0] e, input logic [10:0] f);
    @(posedge sys_clk);
    tok_valid <= 1'b1;
    tok_pid <= p;
    tok_addr <= a;
    tok_ep <= e;
    tok_frame <= f;
    @(posedge sys_clk);
    tok_valid <= 1'b0;
    tok_addr <= ~a;
    tok_ep <= ~e;
    tok_frame <= ~f;
  endtask
endmodule
